// file: uev_top.v
// Purpose: Event mask, channel status and receive holding logic of a serial transceiver.
// Assumes: APB slave on pclk; engine strobes are one-cycle pulses synchronous to pclk.
// Notes: One wait state on every APB access; all outputs come from flip-flops.
//
// Notes on behaviour
// - Writing one to a disable bit clears that mask bit; zero leaves it.
// - Mask register reads one for each enabled source, zero for disabled.
// - Disable, mask and status share one layout; tx done bit 9, idle 8.
// - Receive-available sets on a character, clears on holding read, zero if rx off.
// - Transmit-free is zero while holding is full or break start is pending.
// - Transmit-free and tx done read zero at reset or tx off; enable sets both.
// - Break flag sets on break start or end, held until status clear.
// - Receive DMA end flag follows the receive DMA end signal level.
// - Transmit DMA end flag follows the transmit DMA end signal level.
// - Overrun sets when a byte lands while receive-available is set.
// - Stop-bit error sets on a low stop bit, held until status clear.
// - Parity error on wrong parity, or high parity bit in multi-drop mode.
// - Idle expiry sets on time-out, cleared by start-timeout, zero if value zero.
// - Tx done only with holding and shifter empty and no break being sent.
// - Receive holding returns last character in low eight bits, upper bits zero.
// - Status clear command clears parity, stop-bit, overrun and break flags.
// - Writing one to an enable bit sets that mask bit; zero leaves it.
`timescale 1ns/10ps
`include "uev_regs.vh"
module uev_top (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire rx_char_done,
	input wire [7:0] rx_char,
	input wire rx_stop_low,
	input wire rx_parity_bit,
	input wire rx_parity_expected,
	input wire rx_parity_check,
	input wire multidrop_mode,
	input wire break_start_seen,
	input wire break_end_seen,
	input wire rx_dma_done,
	input wire tx_dma_done,
	input wire idle_expired,
	input wire timeout_value_zero,
	input wire tx_shift_load,
	input wire tx_shift_busy,
	input wire tx_break_active,
	output reg rx_enable,
	output reg tx_enable,
	output reg tx_hold_valid,
	output reg [7:0] tx_hold_data,
	output reg break_start_cmd,
	output reg start_timeout_cmd,
	output reg irq
);
	localparam NEV = `UEV_NUM_EVENTS;
	localparam [1:0] ST_IDLE = 2'b01;
	localparam [1:0] ST_DONE = 2'b10;

	reg [1:0] state_r;
	reg [1:0] state_nxt;
	reg [31:0] rdata_nxt;
	reg err_nxt;
	reg break_seen_r;
	reg stop_err_r;
	reg parity_error_r;
	reg idle_r;
	reg brk_pend_r;
	wire wr_done;
	wire rd_done;
	wire [31:0] wd;
	wire wr_ctrl;
	wire clr_status_cmd;
	wire en_wr;
	wire dis_wr;
	wire rh_read;
	wire [NEV-1:0] mask;
	wire rx_char_avail;
	wire [7:0] rx_hold_char;
	wire overrun_error;
	wire par_bad;
	wire tx_hold_free;
	wire tx_all_done;
	wire [NEV-1:0] status;
	wire irq_nxt;
	reg tx_en_nxt;
	reg rx_en_nxt;
	reg sel_ctrl;
	reg sel_en;
	reg sel_dis;
	reg sel_rh;
	reg sel_th;

	// The request is completed at the edge where pready is seen high.
	assign wr_done = psel && penable && pready && pwrite;
	assign rd_done = psel && penable && pready && !pwrite;
	assign wd = pwdata;
	assign wr_ctrl = wr_done && sel_ctrl;
	assign clr_status_cmd = wr_ctrl && wd[`UEV_CMD_CLR_STATUS];
	assign en_wr = wr_done && sel_en;
	assign dis_wr = wr_done && sel_dis;
	assign rh_read = rd_done && sel_rh;

	// Selects for the registers that have a side effect; others select none.
	always @*
	begin
		sel_ctrl = 1'b0;
		sel_en = 1'b0;
		sel_dis = 1'b0;
		sel_rh = 1'b0;
		sel_th = 1'b0;
		case (paddr)
		`UEV_OFF_CONTROL:
			sel_ctrl = 1'b1;
		`UEV_OFF_IRQ_ENABLE:
			sel_en = 1'b1;
		`UEV_OFF_IRQ_DISABLE:
			sel_dis = 1'b1;
		`UEV_OFF_RX_HOLDING:
			sel_rh = 1'b1;
		`UEV_OFF_TX_HOLDING:
			sel_th = 1'b1;
		default:
			sel_ctrl = 1'b0;
		endcase
	end

	// Disable wins over enable when both appear in one command word.
	always @*
	begin
		rx_en_nxt = rx_enable;
		tx_en_nxt = tx_enable;
		if (wr_ctrl)
		begin
			rx_en_nxt = (rx_enable || wd[`UEV_CMD_RX_EN]) && !wd[`UEV_CMD_RX_DIS];
			tx_en_nxt = (tx_enable || wd[`UEV_CMD_TX_EN]) && !wd[`UEV_CMD_TX_DIS];
		end
	end

	uev_mask #(
		.WIDTH(NEV)
	) u_mask (
		.pclk(pclk),
		.presetn(presetn),
		.en_wr(en_wr),
		.dis_wr(dis_wr),
		.wdata(wd[NEV-1:0]),
		.mask(mask)
	);

	uev_rxhold u_rxhold (
		.pclk(pclk),
		.presetn(presetn),
		.load(rx_char_done),
		.char_in(rx_char),
		.hold_read(rh_read),
		.clr_status(clr_status_cmd),
		.avail_r(rx_char_avail),
		.char_r(rx_hold_char),
		.overrun_r(overrun_error)
	);

	// Multi-drop mode flags any high parity bit instead of a mismatch.
	assign par_bad = rx_parity_check &&
		(multidrop_mode ? rx_parity_bit : (rx_parity_bit != rx_parity_expected));

	assign tx_hold_free = tx_enable && !tx_hold_valid && !brk_pend_r;
	assign tx_all_done = tx_enable && !tx_hold_valid && !tx_shift_busy &&
		!tx_break_active;

	// Shared bit layout of status, mask, enable and disable words.
	assign status[`UEV_BIT_RX_AVAIL] = rx_char_avail && rx_enable;
	assign status[`UEV_BIT_TX_FREE] = tx_hold_free;
	assign status[`UEV_BIT_BREAK] = break_seen_r;
	assign status[`UEV_BIT_RX_DMA] = rx_dma_done;
	assign status[`UEV_BIT_TX_DMA] = tx_dma_done;
	assign status[`UEV_BIT_OVERRUN] = overrun_error;
	assign status[`UEV_BIT_STOP_ERR] = stop_err_r;
	assign status[`UEV_BIT_PARITY] = parity_error_r;
	assign status[`UEV_BIT_IDLE] = idle_r && !timeout_value_zero;
	assign status[`UEV_BIT_TX_DONE] = tx_all_done;

	assign irq_nxt = |(status & mask);

	// Sticky break, stop-bit, parity and idle flags; a new event wins over a clear.
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			break_seen_r <= 1'b0;
			stop_err_r <= 1'b0;
			parity_error_r <= 1'b0;
			idle_r <= 1'b0;
		end
		else
		begin
			if (break_start_seen || break_end_seen)
				break_seen_r <= 1'b1;
			else if (clr_status_cmd)
				break_seen_r <= 1'b0;
			if (rx_stop_low)
				stop_err_r <= 1'b1;
			else if (clr_status_cmd)
				stop_err_r <= 1'b0;
			if (par_bad)
				parity_error_r <= 1'b1;
			else if (clr_status_cmd)
				parity_error_r <= 1'b0;
			if (idle_expired)
				idle_r <= 1'b1;
			else if (wr_ctrl && wd[`UEV_CMD_START_TO])
				idle_r <= 1'b0;
		end
	end

	// Receive and transmit enables and the start-timeout pulse.
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_enable <= 1'b0;
			tx_enable <= 1'b0;
			start_timeout_cmd <= 1'b0;
		end
		else
		begin
			rx_enable <= rx_en_nxt;
			tx_enable <= tx_en_nxt;
			start_timeout_cmd <= wr_ctrl && wd[`UEV_CMD_START_TO];
		end
	end

	// Transmit holding and break-start request; both are dropped when tx goes off.
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tx_hold_valid <= 1'b0;
			tx_hold_data <= `UEV_CHAR_RESET;
			brk_pend_r <= 1'b0;
			break_start_cmd <= 1'b0;
		end
		else
		begin
			if (!tx_en_nxt)
				tx_hold_valid <= 1'b0;
			else if (wr_done && sel_th)
			begin
				tx_hold_valid <= 1'b1;
				tx_hold_data <= wd[7:0];
			end
			else if (tx_shift_load)
				tx_hold_valid <= 1'b0;
			if (!tx_en_nxt)
				brk_pend_r <= 1'b0;
			else if (wr_ctrl && wd[`UEV_CMD_BRK_START] && !tx_break_active)
				brk_pend_r <= 1'b1;
			else if (tx_break_active)
				brk_pend_r <= 1'b0;
			break_start_cmd <= brk_pend_r && tx_en_nxt && !tx_break_active;
		end
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq <= 1'b0;
		else
			irq <= irq_nxt;
	end

	// Read mux and decode, evaluated during the first access cycle.
	always @*
	begin
		rdata_nxt = `UEV_WORD_ZERO;
		err_nxt = 1'b0;
		case (paddr)
		`UEV_OFF_CONTROL:
			err_nxt = !pwrite;
		`UEV_OFF_IRQ_ENABLE:
			err_nxt = !pwrite;
		`UEV_OFF_IRQ_DISABLE:
			err_nxt = !pwrite;
		`UEV_OFF_TX_HOLDING:
			err_nxt = !pwrite;
		`UEV_OFF_IRQ_MASK:
		begin
			rdata_nxt[NEV-1:0] = mask;
			err_nxt = pwrite;
		end
		`UEV_OFF_CHANNEL_STATUS:
		begin
			rdata_nxt[NEV-1:0] = status;
			err_nxt = pwrite;
		end
		`UEV_OFF_RX_HOLDING:
		begin
			rdata_nxt[7:0] = rx_hold_char;
			err_nxt = pwrite;
		end
		default:
			err_nxt = 1'b1;
		endcase
	end

	always @*
	begin
		state_nxt = state_r;
		case (state_r)
		ST_IDLE:
			if (psel && penable)
				state_nxt = ST_DONE;
		ST_DONE:
			state_nxt = ST_IDLE;
		default:
			state_nxt = ST_IDLE;
		endcase
	end

	// Answer one cycle after the access phase opens.
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_r <= ST_IDLE;
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= `UEV_WORD_ZERO;
		end
		else
		begin
			state_r <= state_nxt;
			if (state_r == ST_IDLE && psel && penable)
			begin
				pready <= 1'b1;
				pslverr <= err_nxt;
				prdata <= pwrite ? `UEV_WORD_ZERO : rdata_nxt;
			end
			else
			begin
				pready <= 1'b0;
				pslverr <= 1'b0;
			end
		end
	end
endmodule

// file: uev_regs.vh
// Purpose: Offsets, field positions and reset values of the event and status block.
// Assumes: APB with 32-bit data, one register to an aligned word.
// Notes: Definitions only.
`ifndef UEV_REGS_VH
`define UEV_REGS_VH

`define UEV_OFF_CONTROL 8'h00
`define UEV_OFF_IRQ_ENABLE 8'h08
`define UEV_OFF_IRQ_DISABLE 8'h0C
`define UEV_OFF_IRQ_MASK 8'h10
`define UEV_OFF_CHANNEL_STATUS 8'h14
`define UEV_OFF_RX_HOLDING 8'h18
`define UEV_OFF_TX_HOLDING 8'h1C

`define UEV_NUM_EVENTS 10
`define UEV_BIT_RX_AVAIL 0
`define UEV_BIT_TX_FREE 1
`define UEV_BIT_BREAK 2
`define UEV_BIT_RX_DMA 3
`define UEV_BIT_TX_DMA 4
`define UEV_BIT_OVERRUN 5
`define UEV_BIT_STOP_ERR 6
`define UEV_BIT_PARITY 7
`define UEV_BIT_IDLE 8
`define UEV_BIT_TX_DONE 9

`define UEV_CMD_RX_EN 4
`define UEV_CMD_RX_DIS 5
`define UEV_CMD_TX_EN 6
`define UEV_CMD_TX_DIS 7
`define UEV_CMD_CLR_STATUS 8
`define UEV_CMD_BRK_START 9
`define UEV_CMD_START_TO 11

`define UEV_MASK_RESET 10'h000
`define UEV_CHAR_RESET 8'h00
`define UEV_WORD_ZERO 32'h0000_0000

`endif

// file: uev_mask.v
// Purpose: Event mask with set-by-one enable and clear-by-one disable writes.
// Assumes: Enable and disable writes are single-cycle pulses.
// Notes: Reset clears every mask bit.
`timescale 1ns/10ps
`include "uev_regs.vh"
module uev_mask #(
	parameter WIDTH = `UEV_NUM_EVENTS
)(
	input wire pclk,
	input wire presetn,
	input wire en_wr,
	input wire dis_wr,
	input wire [WIDTH-1:0] wdata,
	output wire [WIDTH-1:0] mask
);
	reg [WIDTH-1:0] mask_r;
	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1)
		begin : g_bit
			always @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					mask_r[i] <= 1'b0;
				else if (en_wr && wdata[i])
					mask_r[i] <= 1'b1;
				else if (dis_wr && wdata[i])
					mask_r[i] <= 1'b0;
			end
		end
	endgenerate
	assign mask = mask_r;
endmodule

// file: uev_rxhold.v
// Purpose: Receive holding register with character-available and overrun flags.
// Assumes: Load, read and clear inputs are single-cycle pulses.
// Notes: A load in the cycle of a read keeps the flag set.
`timescale 1ns/10ps
`include "uev_regs.vh"
module uev_rxhold (
	input wire pclk,
	input wire presetn,
	input wire load,
	input wire [7:0] char_in,
	input wire hold_read,
	input wire clr_status,
	output reg avail_r,
	output reg [7:0] char_r,
	output reg overrun_r
);
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			avail_r <= 1'b0;
			char_r <= `UEV_CHAR_RESET;
			overrun_r <= 1'b0;
		end
		else
		begin
			if (load)
			begin
				avail_r <= 1'b1;
				char_r <= char_in;
			end
			else if (hold_read)
				avail_r <= 1'b0;
			if (load && avail_r)
				overrun_r <= 1'b1;
			else if (clr_status)
				overrun_r <= 1'b0;
		end
	end
endmodule

// file: uev_checker.sv
// Purpose: Port assertions for the event and status block.
// Assumes: One clock, asynchronous active-low reset.
// Notes: Bound to the top module in the testbench.
`timescale 1ns/10ps
`include "uev_regs.vh"
module uev_checker (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire rx_enable,
	input wire tx_enable,
	input wire tx_hold_valid,
	input wire [7:0] tx_hold_data,
	input wire start_timeout_cmd
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire wr = pready && pwrite && !pslverr;
	wire rd = pready && !pwrite && !pslverr;
	wire cmd = wr && paddr == `UEV_OFF_CONTROL;
	chk_ready_wait: assert property (psel && penable && !pready |=> pready)
		else $error("ready late");
	chk_ready_once: assert property (pready |=> !pready)
		else $error("ready held");
	chk_tx_on: assert property (cmd && pwdata[6] && !pwdata[7] |=> tx_enable)
		else $error("tx not enabled");
	chk_tx_off: assert property (cmd && pwdata[7] |=> !tx_enable)
		else $error("tx not disabled");
	chk_rx_on: assert property (cmd && pwdata[4] && !pwdata[5] |=> rx_enable)
		else $error("rx not enabled");
	chk_rx_off: assert property (cmd && pwdata[5] |=> !rx_enable)
		else $error("rx not disabled");
	chk_timeout_pulse: assert property (cmd && pwdata[11] |=> start_timeout_cmd ##1
		!start_timeout_cmd) else $error("start timeout pulse wrong");
	chk_hold_load: assert property (wr && paddr == `UEV_OFF_TX_HOLDING && tx_enable
		|=> tx_hold_valid && tx_hold_data == $past(pwdata[7:0])) else $error("hold load");
	chk_status_top: assert property (rd && paddr == `UEV_OFF_CHANNEL_STATUS
		|-> prdata[31:10] == 22'h0) else $error("status upper bits set");
	chk_char_top: assert property (rd && paddr == `UEV_OFF_RX_HOLDING
		|-> prdata[31:8] == 24'h0) else $error("char upper bits set");
endmodule

// file: uev_line_peer.sv
// Purpose: Line peer and transfer channel model driving the engine strobes.
// Assumes: Tasks are called just after a rising pclk edge.
// Notes: Released data lines show the inverse of their last value.
`timescale 1ns/10ps
module uev_line_peer (
	input wire pclk,
	output wire rx_char_done,
	output logic [7:0] rx_char,
	output wire rx_stop_low,
	output logic rx_parity_bit,
	output logic rx_parity_expected,
	output wire rx_parity_check,
	output wire multidrop_mode,
	output wire break_start_seen,
	output wire break_end_seen,
	output wire rx_dma_done,
	output wire tx_dma_done,
	output wire idle_expired,
	output wire timeout_value_zero,
	output wire tx_shift_load,
	output wire tx_shift_busy,
	output wire tx_break_active
);
	logic [6:0] ev_q = 7'h00;
	logic [5:0] lv_q = 6'h00;
	assign rx_char_done = ev_q[6];
	assign tx_shift_load = ev_q[5];
	assign idle_expired = ev_q[4];
	assign break_end_seen = ev_q[3];
	assign break_start_seen = ev_q[2];
	assign rx_stop_low = ev_q[1];
	assign rx_parity_check = ev_q[0];
	assign multidrop_mode = lv_q[5];
	assign tx_break_active = lv_q[4];
	assign tx_shift_busy = lv_q[3];
	assign timeout_value_zero = lv_q[2];
	assign tx_dma_done = lv_q[1];
	assign rx_dma_done = lv_q[0];
	initial
	begin
		rx_char = 8'h00;
		rx_parity_bit = 1'b0;
		rx_parity_expected = 1'b0;
	end
	task automatic rx_byte(input logic [7:0] c);
		ev_q <= 7'h40;
		rx_char <= c;
		@(posedge pclk);
		ev_q <= 7'h00;
		rx_char <= ~c;
		@(posedge pclk);
	endtask
	task automatic strobe(input logic [5:0] s, input logic pb, input logic pe);
		ev_q <= {1'b0, s};
		rx_parity_bit <= pb;
		rx_parity_expected <= pe;
		@(posedge pclk);
		ev_q <= 7'h00;
		rx_parity_bit <= ~pb;
		rx_parity_expected <= ~pe;
		@(posedge pclk);
	endtask
	task automatic lv(input logic [5:0] v);
		lv_q <= v;
		repeat (3) @(posedge pclk);
	endtask
endmodule

// file: uev_top_tb.sv
// Purpose: Self-checking bench for the event and status block.
// Assumes: 40 MHz pclk, APB master tasks, line peer model.
// Notes: Expected words follow the shared status layout.
`timescale 1ns/10ps
`include "uev_regs.vh"
module uev_top_tb;
	localparam logic [7:0] A_CR = `UEV_OFF_CONTROL;
	localparam logic [7:0] A_EN = `UEV_OFF_IRQ_ENABLE;
	localparam logic [7:0] A_DIS = `UEV_OFF_IRQ_DISABLE;
	localparam logic [7:0] A_MSK = `UEV_OFF_IRQ_MASK;
	localparam logic [7:0] A_CS = `UEV_OFF_CHANNEL_STATUS;
	localparam logic [7:0] A_RH = `UEV_OFF_RX_HOLDING;
	localparam logic [7:0] A_TH = `UEV_OFF_TX_HOLDING;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, se;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, rd;
	int err_total = 0, num_checks = 0, cyc = 0;
	wire [31:0] prdata;
	wire [7:0] rx_char, tx_hold_data;
	wire pready, pslverr, rx_char_done, rx_stop_low, rx_parity_bit, rx_parity_expected;
	wire rx_parity_check, multidrop_mode, break_start_seen, break_end_seen, rx_dma_done;
	wire tx_dma_done, idle_expired, timeout_value_zero, tx_shift_load, tx_shift_busy;
	wire tx_break_active, rx_enable, tx_enable, tx_hold_valid, break_start_cmd;
	wire start_timeout_cmd, irq;
	uev_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .rx_char_done, .rx_char, .rx_stop_low, .rx_parity_bit,
		.rx_parity_expected, .rx_parity_check, .multidrop_mode, .break_start_seen,
		.break_end_seen, .rx_dma_done, .tx_dma_done, .idle_expired, .timeout_value_zero,
		.tx_shift_load, .tx_shift_busy, .tx_break_active, .rx_enable, .tx_enable,
		.tx_hold_valid, .tx_hold_data, .break_start_cmd, .start_timeout_cmd, .irq);
	uev_line_peer i_peer (.pclk, .rx_char_done, .rx_char, .rx_stop_low, .rx_parity_bit,
		.rx_parity_expected, .rx_parity_check, .multidrop_mode, .break_start_seen,
		.break_end_seen, .rx_dma_done, .tx_dma_done, .idle_expired, .timeout_value_zero,
		.tx_shift_load, .tx_shift_busy, .tx_break_active);
	always #12.5 pclk = ~pclk;
	task automatic summarize();
		if (err_total == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e)
		begin
			err_total++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd, e);
	endtask
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			err_total++;
			summarize();
		end
	end
	initial
	begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdc(A_MSK, 32'h0000_0000);
		rdc(A_CS, 32'h0000_0000);
		rdc(A_RH, 32'h0000_0000);
		apb(1'b1, A_EN, 32'hFFFF_FFFF);
		rdc(A_MSK, 32'h0000_03FF);
		apb(1'b1, A_DIS, 32'h0000_0155);
		rdc(A_MSK, 32'h0000_02AA);
		apb(1'b1, A_DIS, 32'h0000_0000);
		rdc(A_MSK, 32'h0000_02AA);
		chk(irq, 32'h0000_0000);
		i_peer.lv(6'h03);
		rdc(A_CS, 32'h0000_0018);
		chk(irq, 32'h0000_0001);
		apb(1'b1, A_DIS, 32'h0000_0008);
		repeat (3) @(posedge pclk);
		chk(irq, 32'h0000_0000);
		i_peer.lv(6'h00);
		rdc(A_CS, 32'h0000_0000);
		apb(1'b1, A_DIS, 32'h0000_03FF);
		rdc(A_MSK, 32'h0000_0000);
		apb(1'b1, A_CR, 32'h0000_0040);
		rdc(A_CS, 32'h0000_0202);
		apb(1'b1, A_TH, 32'h0000_0055);
		rdc(A_CS, 32'h0000_0000);
		chk(tx_hold_data, 32'h0000_0055);
		i_peer.lv(6'h08);
		i_peer.strobe(6'h20, 1'b0, 1'b0);
		rdc(A_CS, 32'h0000_0002);
		i_peer.lv(6'h00);
		rdc(A_CS, 32'h0000_0202);
		apb(1'b1, A_CR, 32'h0000_0200);
		rdc(A_CS, 32'h0000_0200);
		chk(break_start_cmd, 32'h0000_0001);
		i_peer.lv(6'h10);
		rdc(A_CS, 32'h0000_0002);
		i_peer.lv(6'h00);
		apb(1'b1, A_CR, 32'h0000_0080);
		rdc(A_CS, 32'h0000_0000);
		apb(1'b1, A_CR, 32'h0000_0010);
		i_peer.rx_byte(8'hA5);
		rdc(A_CS, 32'h0000_0001);
		rdc(A_RH, 32'h0000_00A5);
		rdc(A_CS, 32'h0000_0000);
		i_peer.rx_byte(8'h11);
		i_peer.rx_byte(8'h22);
		rdc(A_CS, 32'h0000_0021);
		rdc(A_RH, 32'h0000_0022);
		i_peer.rx_byte(8'h33);
		apb(1'b1, A_CR, 32'h0000_0020);
		rdc(A_CS, 32'h0000_0020);
		i_peer.strobe(6'h07, 1'b1, 1'b0);
		rdc(A_CS, 32'h0000_00E4);
		apb(1'b1, A_CR, 32'h0000_0100);
		rdc(A_CS, 32'h0000_0000);
		i_peer.strobe(6'h08, 1'b0, 1'b0);
		rdc(A_CS, 32'h0000_0004);
		i_peer.lv(6'h20);
		i_peer.strobe(6'h01, 1'b1, 1'b1);
		rdc(A_CS, 32'h0000_0084);
		i_peer.lv(6'h00);
		apb(1'b1, A_CR, 32'h0000_0100);
		i_peer.strobe(6'h10, 1'b0, 1'b0);
		rdc(A_CS, 32'h0000_0100);
		apb(1'b1, A_CR, 32'h0000_0800);
		rdc(A_CS, 32'h0000_0000);
		i_peer.strobe(6'h10, 1'b0, 1'b0);
		i_peer.lv(6'h04);
		rdc(A_CS, 32'h0000_0000);
		apb(1'b1, A_EN, 32'h0000_03FF);
		rdc(A_MSK, 32'h0000_03FF);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdc(A_MSK, 32'h0000_0000);
		chk(se, 32'h0000_0000);
		apb(1'b1, A_CS, 32'h0000_03FF);
		chk(se, 32'h0000_0001);
		apb(1'b0, A_EN, 32'h0000_0000);
		chk(se, 32'h0000_0001);
		rdc(A_MSK, 32'h0000_0000);
		apb(1'b0, 8'h04, 32'h0000_0000);
		chk(se, 32'h0000_0001);
		summarize();
	end
endmodule
bind uev_top uev_checker i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pready, .pslverr, .rx_enable, .tx_enable, .tx_hold_valid, .tx_hold_data,
	.start_timeout_cmd);
